//--- hdl/mrs_params.svh
// What this block does
// R1 - Reset pin initialises every state element except the context and the general registers
// R2 - 13-bit counter: word0 low five, word1
// R3 - 12-bit counter: word0 low four, word1
// R4 - Word0 bit 7 loads bank enable flag
// R5 - Counter and flag load same both cases
// R6 - Standby reset keeps context; operation reset spoils
// R7 - Data memory F8H to FDH always spoiled
// R8 - Interrupt status field cleared
// R9 - Bank select register cleared
// R10 - Serial mode register cleared
// R11 - Serial bus control register cleared
// R12 - Slave address kept in standby only
// R13 - Processor clock register cleared
// R14 - System clock register cleared
// R15 - Clock output register cleared
// R16 - Global interrupt enable cleared
// R17 - All three edge mode registers cleared
// R18 - Pull-up select register cleared
// R19 - Hold core until load done, then run
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH

`define MRS_PM_ADDR_HI     13'h0000
`define MRS_PM_ADDR_LO     13'h0001
`define MRS_MBE_BIT        7
`define MRS_DM_FIRST       8'hF8
`define MRS_DM_LAST        8'hFD
`define MRS_UNDEF_NIB      4'hA
`define MRS_SCRUB_LAST     3'h7
`define MRS_TMOD_RESET     8'hFF
`define MRS_ADM_RESET      8'h04
`define MRS_ZERO4          4'h0
`define MRS_ZERO8          8'h00

`endif

//--- hdl/mrs_pkg.sv
package mrs_pkg;

  typedef enum logic [2:0] {
    MRS_ST_ADDR0 = 3'h0,
    MRS_ST_ADDR1 = 3'h1,
    MRS_ST_CAPT  = 3'h3,
    MRS_ST_SCRUB = 3'h2,
    MRS_ST_RUN   = 3'h6
  } mrs_state_t;

  typedef struct packed {
    logic [3:0] processor_clock_reg;
    logic [3:0] system_clock_reg;
    logic [3:0] clock_output_reg;
    logic [3:0] bank_select_reg;
    logic [7:0] serial_mode_reg;
    logic [7:0] serial_bus_control_reg;
    logic [3:0] ext_irq0_edge_mode;
    logic [3:0] ext_irq1_edge_mode;
    logic [3:0] ext_irq2_edge_mode;
    logic [7:0] pullup_select_reg;
    logic [7:0] port_dir_group_a;
    logic [7:0] port_dir_group_b;
    logic [3:0] interval_timer_mode_reg;
    logic [7:0] timer_modulo_reg;
    logic [7:0] converter_mode_reg;
    logic       global_interrupt_enable;
    logic [7:0] interrupt_enable_flags;
    logic [1:0] interrupt_status_field;
    logic [2:0] skip_flags;
  } mrs_ctl_t;

  typedef struct packed {
    logic        carry_flag;
    logic [7:0]  slave_address_reg;
    logic [7:0]  serial_shift_reg;
    logic [15:0] bit_sequence_buffers;
  } mrs_ctx_t;

  typedef struct packed {
    logic       we;
    logic [2:0] waddr;
    logic [3:0] wdata;
    logic [2:0] raddr;
  } mrs_gpr_req_t;

endpackage : mrs_pkg

//--- hdl/mrs_gpr_mem.sv
`timescale 1ns/100ps
module mrs_gpr_mem #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  // No reset: contents survive a reset taken in standby
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : mrs_gpr_mem

//--- hdl/mrs_reset_init.sv
`timescale 1ns/100ps
`include "mrs_params.svh"
module mrs_reset_init import mrs_pkg::*; #(
  parameter int PC_WIDTH = 13
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_standby,
  input  wire logic [7:0]   i_pm_data,
  input  wire logic         i_ctl_we,
  input  wire mrs_ctl_t     i_ctl_wdata,
  input  wire logic         i_ctx_we,
  input  wire mrs_ctx_t     i_ctx_wdata,
  input  wire mrs_gpr_req_t i_gpr,
  output logic [12:0]       o_pm_addr,
  output logic [PC_WIDTH-1:0] o_pc,
  output logic              o_bank_enable,
  output logic              o_core_run,
  output logic              o_ctx_undefined,
  output mrs_ctl_t          o_ctl,
  output mrs_ctx_t          o_ctx,
  output logic [3:0]        o_gpr_rdata,
  output logic              o_dmem_we,
  output logic [7:0]        o_dmem_addr,
  output logic [3:0]        o_dmem_wdata
);

  localparam int HI_BITS = PC_WIDTH - 8;

  localparam mrs_ctl_t CTL_RESET = '{
    processor_clock_reg:     `MRS_ZERO4,
    system_clock_reg:        `MRS_ZERO4,
    clock_output_reg:        `MRS_ZERO4,
    bank_select_reg:         `MRS_ZERO4,
    serial_mode_reg:         `MRS_ZERO8,
    serial_bus_control_reg:  `MRS_ZERO8,
    ext_irq0_edge_mode:      `MRS_ZERO4,
    ext_irq1_edge_mode:      `MRS_ZERO4,
    ext_irq2_edge_mode:      `MRS_ZERO4,
    pullup_select_reg:       `MRS_ZERO8,
    port_dir_group_a:        `MRS_ZERO8,
    port_dir_group_b:        `MRS_ZERO8,
    interval_timer_mode_reg: `MRS_ZERO4,
    timer_modulo_reg:        `MRS_TMOD_RESET,
    converter_mode_reg:      `MRS_ADM_RESET,
    global_interrupt_enable: 1'b0,
    interrupt_enable_flags:  `MRS_ZERO8,
    interrupt_status_field:  2'h0,
    skip_flags:              3'h0
  };

  localparam mrs_ctx_t CTX_UNDEF = '{
    carry_flag:           1'b0,
    slave_address_reg:    {2{`MRS_UNDEF_NIB}},
    serial_shift_reg:     {2{`MRS_UNDEF_NIB}},
    bit_sequence_buffers: {4{`MRS_UNDEF_NIB}}
  };

  mrs_state_t       state;
  mrs_state_t       next_state;
  logic [2:0]       cnt;
  logic             mode_standby;
  logic [HI_BITS-1:0] pc_hi;
  logic             mbe_word0;
  logic [1:0]       rst_sync;

  // Pin reset asserts at once, releases through two flops
  wire logic rst_n = rst_sync[1];

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync <= 2'h0; // [R1]
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end

  // Sequencer decode
  wire logic st_addr0   = (state == MRS_ST_ADDR0);
  wire logic st_addr1   = (state == MRS_ST_ADDR1);
  wire logic st_capt    = (state == MRS_ST_CAPT);
  wire logic st_scrub   = (state == MRS_ST_SCRUB);
  wire logic st_run     = (state == MRS_ST_RUN);
  wire logic scrub_done = st_scrub && (cnt == `MRS_SCRUB_LAST);
  wire logic dm_hit     = st_scrub && ((`MRS_DM_FIRST + {5'h00, cnt}) <= `MRS_DM_LAST);
  wire logic ctx_spoil  = st_scrub && !mode_standby;
  wire logic gpr_we     = ctx_spoil || (st_run && i_gpr.we);
  wire logic [2:0] gpr_waddr = ctx_spoil ? cnt : i_gpr.waddr;
  wire logic [3:0] gpr_wdata = ctx_spoil ? `MRS_UNDEF_NIB : i_gpr.wdata;

  always_comb begin
    next_state = state;
    unique case (state)
      MRS_ST_ADDR0: next_state = MRS_ST_ADDR1;
      MRS_ST_ADDR1: next_state = MRS_ST_CAPT;
      MRS_ST_CAPT:  next_state = MRS_ST_SCRUB;
      MRS_ST_SCRUB: next_state = scrub_done ? MRS_ST_RUN : MRS_ST_SCRUB;
      MRS_ST_RUN:   next_state = MRS_ST_RUN;
      default:      next_state = MRS_ST_ADDR0;
    endcase
  end

  // Sequencer, held at its first state while the pin is low
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MRS_ST_ADDR0; // [R1] [R19]
      cnt   <= 3'h0;
    end else begin
      state <= next_state;
      cnt   <= st_scrub ? cnt + 3'h1 : 3'h0;
    end
  end

  // Reset cause caught after release, in the first cycle
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_standby <= 1'b0;
    end else if (st_addr0) begin
      mode_standby <= i_standby; // [R6]
    end
  end

  // Program memory fetch of the two start words
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pm_addr <= `MRS_PM_ADDR_HI;
      pc_hi     <= '0;
      mbe_word0 <= 1'b0;
    end else begin
      if (st_addr0) begin
        o_pm_addr <= `MRS_PM_ADDR_LO;
      end
      if (st_addr1) begin
        pc_hi     <= i_pm_data[HI_BITS-1:0]; // [R2] [R3] [R5]
        mbe_word0 <= i_pm_data[`MRS_MBE_BIT]; // [R4]
      end
    end
  end

  // Counter, bank enable and run release
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pc          <= '0;
      o_bank_enable <= 1'b0;
      o_core_run    <= 1'b0; // [R19]
    end else begin
      if (st_capt) begin
        o_pc          <= {pc_hi, i_pm_data}; // [R2] [R3] [R5]
        o_bank_enable <= mbe_word0; // [R4]
      end
      o_core_run <= o_core_run || scrub_done; // [R19]
    end
  end

  // Control registers loaded with CTL_RESET by any reset, core writes once running
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ctl <= CTL_RESET; // [R8] [R9] [R10] [R11] [R13] [R14] [R15] [R16] [R17] [R18]
    end else if (st_run && i_ctl_we) begin
      o_ctl <= i_ctl_wdata;
    end
  end

  // Context has no reset; spoiled only after an operation reset
  always_ff @(posedge i_sys_clk) begin
    if (ctx_spoil) begin
      o_ctx <= CTX_UNDEF; // [R6] [R12]
    end else if (st_run && i_ctx_we) begin
      o_ctx <= i_ctx_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ctx_undefined <= 1'b0;
    end else if (st_capt) begin
      o_ctx_undefined <= !mode_standby; // [R6]
    end
  end

  // Data memory window spoiled on every reset
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dmem_we    <= 1'b0;
      o_dmem_addr  <= `MRS_DM_FIRST;
      o_dmem_wdata <= `MRS_ZERO4;
    end else begin
      o_dmem_we    <= dm_hit; // [R7]
      o_dmem_addr  <= `MRS_DM_FIRST + {5'h00, cnt}; // [R7]
      o_dmem_wdata <= `MRS_UNDEF_NIB;
    end
  end

  // General registers
  mrs_gpr_mem #(
    .WIDTH (4),
    .DEPTH (8),
    .AW    (3)
  ) u_gpr (
    .i_sys_clk (i_sys_clk),
    .i_we      (gpr_we), // [R6]
    .i_waddr   (gpr_waddr),
    .i_wdata   (gpr_wdata),
    .i_raddr   (i_gpr.raddr),
    .o_rdata   (o_gpr_rdata)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  a_pc_low_load: assert property ( // [R2] [R3]
    st_capt |=> o_pc[7:0] == $past(i_pm_data))
    else $error("counter low byte not from word 1");

  a_pc_high_load: assert property ( // [R2] [R3] [R5]
    st_addr1 ##1 st_capt |=> o_pc[PC_WIDTH-1:8] == $past(i_pm_data[HI_BITS-1:0], 2))
    else $error("counter high bits not from word 0");

  a_bank_enable_load: assert property ( // [R4]
    st_addr1 |-> ##2 o_bank_enable == $past(i_pm_data[`MRS_MBE_BIT], 2))
    else $error("bank enable not from word 0 bit 7");

  a_run_release_time: assert property ( // [R19]
    st_addr0 |-> (!o_core_run)[*8] ##1 (!o_core_run)[*3]
      ##1 (o_core_run && o_pc == $past(o_pc)))
    else $error("core released at wrong time");

  a_ctl_held_clear: assert property ( // [R8] [R9] [R16] [R17] [R18]
    !o_core_run |-> o_ctl == CTL_RESET)
    else $error("control state not cleared before run");

  a_dmem_window: assert property ( // [R7]
    o_dmem_we |-> (o_dmem_addr >= `MRS_DM_FIRST) && (o_dmem_addr <= `MRS_DM_LAST))
    else $error("scrub write outside window");

  a_dmem_count: assert property ( // [R7]
    $rose(st_scrub) |-> ##1 o_dmem_we[*6] ##1 !o_dmem_we)
    else $error("window scrub not six writes");

  a_ctx_retained: assert property ( // [R6] [R12]
    (st_scrub && mode_standby) |=> $stable(o_ctx))
    else $error("context lost on standby reset");

  a_ctx_spoiled: assert property ( // [R6] [R12]
    (scrub_done && !mode_standby) |=> o_ctx == CTX_UNDEF && o_ctx_undefined)
    else $error("context not spoiled on operation reset");

  // Clear values hold until the core runs
  a_serial_regs_clear: assert property ( // [R10] [R11]
    !o_core_run |-> o_ctl.serial_mode_reg == `MRS_ZERO8
      && o_ctl.serial_bus_control_reg == `MRS_ZERO8)
    else $error("serial registers not cleared");

  a_clock_regs_clear: assert property ( // [R13] [R14] [R15]
    !o_core_run |-> o_ctl.processor_clock_reg == `MRS_ZERO4
      && o_ctl.system_clock_reg == `MRS_ZERO4 && o_ctl.clock_output_reg == `MRS_ZERO4)
    else $error("clock registers not cleared");

  a_irq_mode_clear: assert property ( // [R16] [R17]
    !o_core_run |-> !o_ctl.global_interrupt_enable
      && o_ctl.ext_irq0_edge_mode == `MRS_ZERO4 && o_ctl.ext_irq1_edge_mode == `MRS_ZERO4
      && o_ctl.ext_irq2_edge_mode == `MRS_ZERO4)
    else $error("interrupt controls not cleared");

  a_status_skip_clear: assert property ( // [R8]
    !o_core_run |-> o_ctl.interrupt_status_field == 2'h0 && o_ctl.skip_flags == 3'h0)
    else $error("status or skip flags not cleared");

  // Writes refused until the core runs
  a_write_refused: assert property ( // [R19]
    (!st_run && i_ctl_we) |=> $stable(o_ctl))
    else $error("control write taken before run");

  a_ctx_write_refused: assert property ( // [R19]
    (!st_run && !ctx_spoil && i_ctx_we) |=> $stable(o_ctx))
    else $error("context write taken before run");

  a_run_sticky: assert property ( // [R5] [R19]
    o_core_run |=> o_core_run && $stable(o_pc) && $stable(o_bank_enable))
    else $error("run state or start counter moved");

  // Start word fetch and reset cause
  a_pm_addr_order: assert property ( // [R2] [R3]
    st_addr0 |-> (o_pm_addr == `MRS_PM_ADDR_HI) ##1 (o_pm_addr == `MRS_PM_ADDR_LO))
    else $error("start words fetched out of order");

  a_standby_capture: assert property ( // [R6]
    st_addr0 |=> mode_standby == $past(i_standby))
    else $error("reset cause not captured");

  a_ctx_flag: assert property ( // [R6]
    st_capt |=> o_ctx_undefined == !mode_standby)
    else $error("context flag wrong for reset cause");

  a_standby_gpr_kept: assert property ( // [R6]
    (st_scrub && mode_standby) |-> !gpr_we)
    else $error("register written on standby reset");

  // Data memory window scrub
  a_scrub_data: assert property ( // [R7]
    o_dmem_we |-> o_dmem_wdata == `MRS_UNDEF_NIB)
    else $error("scrub data not the undefined pattern");

  a_dmem_order: assert property ( // [R7]
    (o_dmem_we && o_dmem_addr != `MRS_DM_FIRST)
      |-> $past(o_dmem_we) && o_dmem_addr == $past(o_dmem_addr) + 8'h01)
    else $error("scrub addresses not consecutive");

endmodule : mrs_reset_init

//--- testbench/mrs_rst_src.sv
`timescale 1ns/100ps
module mrs_rst_src (
  input  wire logic        i_sys_clk,
  input  wire logic [12:0] i_pm_addr,
  output logic             o_reset_n,
  output logic [7:0]       o_pm_data
);
  logic [7:0] word0 = 8'h00;
  logic [7:0] word1 = 8'h00;
  initial o_reset_n = 1'b0;
  initial o_pm_data = 8'h00;
  // Program memory, one cycle late; other words toggle
  always @(posedge i_sys_clk) begin
    o_pm_data <= (i_pm_addr == 13'h0000) ? word0 :
                 (i_pm_addr == 13'h0001) ? word1 : ~o_pm_data;
  end
  // Reset pulse of n cycles with new start words
  task automatic pulse(input logic [7:0] w0, input logic [7:0] w1, input int n);
    @(posedge i_sys_clk);
    word0     <= w0;
    word1     <= w1;
    o_reset_n <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    o_reset_n <= 1'b1;
  endtask : pulse
endmodule : mrs_rst_src

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb import mrs_pkg::*;;
  logic         i_sys_clk = 1'b0;
  logic         i_reset_n;
  logic         i_standby;
  logic [7:0]   i_pm_data;
  logic         i_ctl_we;
  mrs_ctl_t     i_ctl_wdata;
  logic         i_ctx_we;
  mrs_ctx_t     i_ctx_wdata;
  mrs_gpr_req_t i_gpr;
  logic [12:0]  o_pm_addr;
  logic [12:0]  o_pc;
  logic [11:0]  pc12;
  logic         o_bank_enable;
  logic         o_core_run;
  logic         o_ctx_undefined;
  mrs_ctl_t     o_ctl;
  mrs_ctx_t     o_ctx;
  logic [3:0]   o_gpr_rdata;
  logic         o_dmem_we;
  logic [7:0]   o_dmem_addr;
  logic [3:0]   o_dmem_wdata;
  int           n_mismatch = 0;
  int           comparisons = 0;
  int           cyc = 0;
  int           scrub_q[$];
  mrs_ctl_t     ctl_rst;
  mrs_ctl_t     ctl_exp;
  mrs_ctx_t     ctx_exp;
  logic [3:0]   gpr_exp;
  logic [7:0]   w0;
  logic [7:0]   w1;
  logic [127:0] r;

  always #5 i_sys_clk = ~i_sys_clk;

  mrs_rst_src src (.i_sys_clk(i_sys_clk), .i_pm_addr(o_pm_addr),
    .o_reset_n(i_reset_n), .o_pm_data(i_pm_data));

  mrs_reset_init #(.PC_WIDTH(13)) DUT (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_standby(i_standby), .i_pm_data(i_pm_data), .i_ctl_we(i_ctl_we),
    .i_ctl_wdata(i_ctl_wdata), .i_ctx_we(i_ctx_we), .i_ctx_wdata(i_ctx_wdata),
    .i_gpr(i_gpr), .o_pm_addr(o_pm_addr), .o_pc(o_pc), .o_bank_enable(o_bank_enable),
    .o_core_run(o_core_run), .o_ctx_undefined(o_ctx_undefined), .o_ctl(o_ctl),
    .o_ctx(o_ctx), .o_gpr_rdata(o_gpr_rdata), .o_dmem_we(o_dmem_we),
    .o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata));

  mrs_reset_init #(.PC_WIDTH(12)) dut_pc12 (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_standby(i_standby), .i_pm_data(i_pm_data), .i_ctl_we(i_ctl_we),
    .i_ctl_wdata(i_ctl_wdata), .i_ctx_we(i_ctx_we), .i_ctx_wdata(i_ctx_wdata),
    .i_gpr(i_gpr), .o_pm_addr(), .o_pc(pc12), .o_bank_enable(), .o_core_run(),
    .o_ctx_undefined(), .o_ctl(), .o_ctx(), .o_gpr_rdata(), .o_dmem_we(),
    .o_dmem_addr(), .o_dmem_wdata());

  // Scrub write monitor
  always @(negedge i_sys_clk) begin
    if (o_dmem_we === 1'b1) begin
      scrub_q.push_back(int'(o_dmem_addr));
      check(o_dmem_wdata, 4'hA, "scrub data");
    end
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, what);
    end
  endtask : check

  task automatic do_reset(input logic sb, input int n);
    int k;
    w0 = 8'($urandom);
    w1 = 8'($urandom);
    scrub_q.delete();
    @(posedge i_sys_clk);
    i_standby      <= sb;
    i_ctl_wdata    <= '1;
    i_ctx_wdata    <= '0;
    i_gpr.wdata    <= ~gpr_exp;
    src.pulse(w0, w1, n);
    i_ctl_we       <= 1'b1;
    i_ctx_we       <= 1'b1;
    i_gpr.we       <= 1'b1;
    #1;
    check(o_pm_addr, 13'h0000, "start word 0 address");
    repeat (4) @(posedge i_sys_clk);
    i_ctl_we <= 1'b0;
    i_ctx_we <= 1'b0;
    i_gpr.we <= 1'b0;
    k = 0;
    while (o_core_run !== 1'b1 && k < 20) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    check(o_core_run, 1'b1, "core not started");
    check(o_pm_addr, 13'h0001, "start word 1 address");
    check(o_pc, {w0[4:0], w1}, "start counter");
    check(pc12, {w0[3:0], w1}, "short start counter");
    check(o_bank_enable, w0[7], "bank enable");
    check(o_ctx_undefined, !sb, "context flag");
    check(o_ctl, ctl_rst, "control values");
    check(scrub_q.size(), 6, "scrub count");
    foreach (scrub_q[i]) check(scrub_q[i], 248 + i, "scrub address");
    if (sb) begin
      check(o_ctx, ctx_exp, "kept context");
      check(o_gpr_rdata, gpr_exp, "kept register");
    end else begin
      check(o_ctx, {1'b0, {8{4'hA}}}, "spoiled context");
      check(o_gpr_rdata, 4'hA, "spoiled register");
    end
  endtask : do_reset

  task automatic write_all();
    r = {$urandom, $urandom, $urandom, $urandom};
    ctl_exp = mrs_ctl_t'(r[$bits(mrs_ctl_t)-1:0]);
    ctx_exp = mrs_ctx_t'(r[127:127-$bits(mrs_ctx_t)+1]);
    gpr_exp = r[63:60];
    @(posedge i_sys_clk);
    i_ctl_we    <= 1'b1;
    i_ctl_wdata <= ctl_exp;
    i_ctx_we    <= 1'b1;
    i_ctx_wdata <= ctx_exp;
    i_gpr.we    <= 1'b1;
    i_gpr.wdata <= gpr_exp;
    @(posedge i_sys_clk);
    i_ctl_we <= 1'b0;
    i_ctx_we <= 1'b0;
    i_gpr.we <= 1'b0;
    #1;
    check(o_ctl, ctl_exp, "control write");
    check(o_ctx, ctx_exp, "context write");
    repeat (2) @(posedge i_sys_clk);
    #1;
    check(o_gpr_rdata, gpr_exp, "register write");
  endtask : write_all

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    void'($urandom(32'h4656cb15));
    i_standby   = 1'b0;
    i_ctl_we    = 1'b0;
    i_ctl_wdata = '0;
    i_ctx_we    = 1'b0;
    i_ctx_wdata = '0;
    i_gpr       = '0;
    i_gpr.raddr = 3'h3;
    i_gpr.waddr = 3'h3;
    gpr_exp     = 4'h0;
    ctl_rst     = '0;
    ctl_rst.timer_modulo_reg   = 8'hFF;
    ctl_rst.converter_mode_reg = 8'h04;
    do_reset(1'b0, 2);
    write_all();
    $display("test 0 done");
    for (int t = 1; t < 9; t++) begin
      do_reset(t[0], 1 + t % 4);
      write_all();
      $display("test %0d done", t);
    end
    stop_test();
  end
endmodule : tb
